// ### dsc_pkg.sv
// Constants and types shared by the debug scan chain select block.
package dsc_pkg;
   // Widths of the TAP-facing buses.
   localparam int unsigned IR_W = 4;
   localparam int unsigned IR_OUT_W = 5;
   localparam int unsigned TAP_W = 4;
   localparam int unsigned CHAIN_NUM_W = 5;
   localparam int unsigned WORD_W = 32;

   // TAP instruction codes this block decodes.
   localparam logic [3:0] IR_EXTERNAL_TEST = 4'h0;
   localparam logic [3:0] IR_CHAIN_SELECT = 4'h2;
   localparam logic [3:0] IR_INTERNAL_TEST = 4'hC;

   // TAP state codes for the three data-register states that matter here.
   localparam logic [3:0] TAP_CAPTURE_DR = 4'h6;
   localparam logic [3:0] TAP_SHIFT_DR = 4'h2;
   localparam logic [3:0] TAP_UPDATE_DR = 4'h5;

   // Chain select register capture value and chain numbering.
   localparam logic [4:0] SEL_CAPTURE_VAL = 5'h10;
   localparam logic [4:0] CHAIN_RESET = 5'h03;
   localparam logic [4:0] CHAIN_CORE = 5'h01;
   localparam logic [4:0] CHAIN_BPU = 5'h02;
   localparam logic [4:0] CHAIN_EXT = 5'h03;
   localparam int unsigned CHAIN_UNASSIGNED_BIT = 4;

   // Core debug chain layout, bit 0 nearest the serial input.
   localparam int unsigned CORE_LEN = 67;
   localparam int unsigned CORE_FETCH_MSB = 31;
   localparam int unsigned CORE_SPEED_BIT = 32;
   localparam int unsigned CORE_WTB_BIT = 33;
   localparam int unsigned CORE_UNUSED_BIT = 34;
   localparam int unsigned CORE_DATA_LSB = 35;
   localparam int unsigned CORE_DATA_MSB = 66;

   // Breakpoint-unit programming chain layout, bit 0 nearest the serial output.
   localparam int unsigned BPU_LEN = 38;
   localparam int unsigned BPU_RW_BIT = 37;
   localparam int unsigned BPU_ADDR_MSB = 36;
   localparam int unsigned BPU_ADDR_LSB = 32;
   localparam int unsigned BPU_DATA_MSB = 31;

   // Serial path currently placed between the test data pins.
   typedef enum logic [2:0] {
      DSC_PATH_NONE,
      DSC_PATH_SELECT,
      DSC_PATH_CORE,
      DSC_PATH_BPU,
      DSC_PATH_EXT
   } dsc_path_t;
endpackage

// ### dsc_ctrl_if.sv
// Control bundle between the scan controller and the chain datapath.
`timescale 1ns/1ps
interface dsc_ctrl_if;
   logic [3:0] tap_state;
   logic [3:0] ir_code;
   logic dbg_en;
   logic [4:0] active;
   logic capture;
   logic shift;
   logic update;
   logic test_mode;
   dsc_pkg::dsc_path_t path;

   modport ctrl (
      input tap_state, ir_code, dbg_en, active,
      output capture, shift, update, test_mode, path
   );
   modport chains (
      output tap_state, ir_code, dbg_en, active,
      input capture, shift, update, test_mode, path
   );
endinterface

// ### dsc_scan_ctrl.sv
// Decoder turning TAP state and instruction into scan cell controls.
`timescale 1ns/1ps
module dsc_scan_ctrl (
   dsc_ctrl_if.ctrl c
);
   logic is_select;
   logic is_test;
   logic is_ext_test;
   logic ext_chain;

   // Strobes are qualified by the debug enable so every step is one enabled edge.
   always_comb begin
      c.capture = c.dbg_en && (c.tap_state == dsc_pkg::TAP_CAPTURE_DR);
      c.shift = c.dbg_en && (c.tap_state == dsc_pkg::TAP_SHIFT_DR);
      c.update = c.dbg_en && (c.tap_state == dsc_pkg::TAP_UPDATE_DR);
   end

   // Instruction decode for the data path choice.
   always_comb begin
      is_select = (c.ir_code == dsc_pkg::IR_CHAIN_SELECT);
      is_test = (c.ir_code == dsc_pkg::IR_INTERNAL_TEST);
      is_ext_test = (c.ir_code == dsc_pkg::IR_EXTERNAL_TEST);
      ext_chain = (c.active == dsc_pkg::CHAIN_EXT) ||
         c.active[dsc_pkg::CHAIN_UNASSIGNED_BIT];
      c.test_mode = is_test;
   end

   // Pick the serial path; reserved chain numbers get no path at all.
   always_comb begin
      c.path = dsc_pkg::DSC_PATH_NONE;
      if (is_select) begin
         c.path = dsc_pkg::DSC_PATH_SELECT;
      end else if (is_test) begin
         if (c.active == dsc_pkg::CHAIN_CORE) begin
            c.path = dsc_pkg::DSC_PATH_CORE;
         end else if (c.active == dsc_pkg::CHAIN_BPU) begin
            c.path = dsc_pkg::DSC_PATH_BPU;
         end else if (ext_chain) begin
            c.path = dsc_pkg::DSC_PATH_EXT;
         end
      end else if (is_ext_test && ext_chain) begin
         c.path = dsc_pkg::DSC_PATH_EXT;
      end
   end
endmodule // dsc_scan_ctrl

// ### dsc_scan_chain_select.sv
// Debug scan datapath: chain select register, core debug and breakpoint chains.
`timescale 1ns/1ps
module dsc_scan_chain_select (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_debug_clock_enable,
   input wire logic i_memory_clock_enable,
   input wire logic i_in_debug,
   input wire logic [3:0] i_ir_code,
   input wire logic [3:0] i_tap_state,
   input wire logic i_test_data_in_pin,
   output logic o_test_data_out_pin,
   output logic [4:0] o_active_chain_number,
   output logic [4:0] o_current_instruction_out,
   output logic [3:0] o_tap_state_out,
   output logic o_external_chain_serial_in,
   input wire logic i_external_chain_serial_return,
   input wire logic [31:0] i_sys_fetch_word,
   input wire logic [31:0] i_sys_rdata,
   input wire logic [31:0] i_core_wdata,
   input wire logic i_core_write,
   input wire logic i_debug_entry,
   input wire logic i_entry_watchpoint,
   input wire logic i_watch_then_break,
   output logic [31:0] o_instruction_bus,
   output logic [31:0] o_core_rdata,
   output logic [31:0] o_sys_wdata,
   output logic o_system_speed_flag,
   output logic o_watch_then_break_flag,
   output logic o_core_clock_enable,
   output logic [4:0] o_bpu_addr,
   output logic [31:0] o_bpu_wdata,
   output logic o_bpu_write,
   output logic o_bpu_read,
   input wire logic [31:0] i_bpu_rdata
);
   // Every flip-flop of the block lives in this one record.
   typedef struct packed {
      logic [1:0] tdi_sync;
      logic [1:0] ret_sync;
      logic [4:0] sel_sr;
      logic [4:0] active;
      logic [66:0] core_sr;
      logic [31:0] fetch_par;
      logic [31:0] data_par;
      logic speed_par;
      logic wtb_par;
      logic entry_pending;
      logic [37:0] bpu_sr;
      logic tdo;
      logic ext_sdin;
      logic [31:0] fetch_out;
      logic [31:0] rdata_out;
      logic [31:0] wdata_out;
      logic speed_out;
      logic wtb_out;
      logic [4:0] bpu_addr;
      logic [31:0] bpu_wdata;
      logic bpu_wr;
      logic bpu_rd;
      logic core_clk_en;
      logic [4:0] ir_out;
      logic [3:0] tap_out;
   } dsc_state_t;

   dsc_state_t st_ff;
   dsc_state_t nxt_st;

   logic tdi;
   logic ext_ret;
   logic core_test;
   logic [31:0] cap_data;
   logic [31:0] cap_data_rev;
   logic [31:0] sr_data;

   dsc_ctrl_if ctl ();

   // The controller sees the TAP state and the current instruction directly;
   // both come from the TAP logic on this same clock, so no synchroniser.
   assign ctl.tap_state = i_tap_state;
   assign ctl.ir_code = i_ir_code;
   assign ctl.dbg_en = i_debug_clock_enable;
   assign ctl.active = st_ff.active;

   dsc_scan_ctrl u_ctrl (
      .c(ctl)
   );

   // Only the second stage of each pin synchroniser is read by the logic.
   assign tdi = st_ff.tdi_sync[1];
   assign ext_ret = st_ff.ret_sync[1];
   assign core_test = ctl.test_mode && (st_ff.active == dsc_pkg::CHAIN_CORE);

   // What the data output cells capture: write data during a core write,
   // otherwise the read data presented by the system.
   assign cap_data = i_core_write ? i_core_wdata : i_sys_rdata;

   // The data field runs from bit 31 at chain bit 35 to bit 0 at chain bit 66,
   // so it is mirrored both on the way in and on the way out.
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_data_mirror
         assign cap_data_rev[gi] = cap_data[31 - gi];
         assign sr_data[gi] = st_ff.core_sr[dsc_pkg::CORE_DATA_MSB - gi];
      end
   endgenerate

   // Next-state logic for all chains, the select register and the outputs.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.tdi_sync = {st_ff.tdi_sync[0], i_test_data_in_pin};
      nxt_st.ret_sync = {st_ff.ret_sync[0], i_external_chain_serial_return};
      nxt_st.bpu_wr = 1'b0;
      nxt_st.bpu_rd = 1'b0;

      case (ctl.path)
         dsc_pkg::DSC_PATH_SELECT: begin
            if (ctl.capture) begin
               nxt_st.sel_sr = dsc_pkg::SEL_CAPTURE_VAL;
            end else if (ctl.shift) begin
               nxt_st.tdo = st_ff.sel_sr[0];
               nxt_st.sel_sr = {tdi, st_ff.sel_sr[4:1]};
            end else if (ctl.update) begin
               nxt_st.active = st_ff.sel_sr;
            end
         end
         dsc_pkg::DSC_PATH_CORE: begin
            if (ctl.capture) begin
               // Input cells copy the system side, data cells the core write data or the system read data.
               nxt_st.core_sr[dsc_pkg::CORE_FETCH_MSB:0] = i_sys_fetch_word;
               nxt_st.core_sr[dsc_pkg::CORE_UNUSED_BIT] = 1'b0;
               nxt_st.core_sr[dsc_pkg::CORE_DATA_MSB:dsc_pkg::CORE_DATA_LSB] =
                  cap_data_rev;
               if (st_ff.entry_pending) begin
                  nxt_st.core_sr[dsc_pkg::CORE_SPEED_BIT] = i_entry_watchpoint;
                  nxt_st.core_sr[dsc_pkg::CORE_WTB_BIT] = i_watch_then_break;
                  nxt_st.entry_pending = 1'b0;
               end else begin
                  nxt_st.core_sr[dsc_pkg::CORE_SPEED_BIT] = st_ff.speed_par;
                  nxt_st.core_sr[dsc_pkg::CORE_WTB_BIT] = st_ff.wtb_par;
               end
            end else if (ctl.shift) begin
               nxt_st.tdo = st_ff.core_sr[dsc_pkg::CORE_DATA_MSB];
               nxt_st.core_sr = {st_ff.core_sr[dsc_pkg::CORE_DATA_MSB - 1:0], tdi};
            end else if (ctl.update) begin
               nxt_st.fetch_par = st_ff.core_sr[dsc_pkg::CORE_FETCH_MSB:0];
               nxt_st.speed_par = st_ff.core_sr[dsc_pkg::CORE_SPEED_BIT];
               nxt_st.wtb_par = st_ff.core_sr[dsc_pkg::CORE_WTB_BIT];
               nxt_st.data_par = sr_data;
            end
         end
         dsc_pkg::DSC_PATH_BPU: begin
            // Capture deliberately leaves this chain alone.
            if (ctl.shift) begin
               nxt_st.tdo = st_ff.bpu_sr[0];
               nxt_st.bpu_sr = {tdi, st_ff.bpu_sr[dsc_pkg::BPU_RW_BIT:1]};
            end else if (ctl.update) begin
               nxt_st.bpu_addr =
                  st_ff.bpu_sr[dsc_pkg::BPU_ADDR_MSB:dsc_pkg::BPU_ADDR_LSB];
               nxt_st.bpu_wdata = st_ff.bpu_sr[dsc_pkg::BPU_DATA_MSB:0];
               nxt_st.bpu_wr = st_ff.bpu_sr[dsc_pkg::BPU_RW_BIT];
               nxt_st.bpu_rd = !st_ff.bpu_sr[dsc_pkg::BPU_RW_BIT];
            end
         end
         dsc_pkg::DSC_PATH_EXT: begin
            // The external chain is a pure pass-through; its own cells capture.
            if (ctl.shift) begin
               nxt_st.tdo = ext_ret;
               nxt_st.ext_sdin = tdi;
            end
         end
         default: begin
         end
      endcase

      // Read data from the breakpoint unit lands in the data field one cycle
      // after the read strobe, ready for the next scan out.
      if (st_ff.bpu_rd) begin
         nxt_st.bpu_sr[dsc_pkg::BPU_DATA_MSB:0] = i_bpu_rdata;
      end

      // A new debug entry arms the flag capture; placed last so it beats the
      // clear that a capture in the same cycle would make.
      if (i_debug_entry) begin
         nxt_st.entry_pending = 1'b1;
      end

      // Scan cell multiplexers: test mode on the core chain drives the chain's parallel copy to
      // the core and the serial contents to the system.
      nxt_st.fetch_out = core_test ? st_ff.fetch_par : i_sys_fetch_word;
      nxt_st.rdata_out = core_test ? st_ff.data_par : i_sys_rdata;
      nxt_st.wdata_out = core_test ? sr_data : i_core_wdata;
      nxt_st.speed_out = st_ff.speed_par;
      nxt_st.wtb_out = st_ff.wtb_par;

      // One clock, two qualifiers: the debug enable wins in debug state.
      nxt_st.core_clk_en = i_in_debug ? i_debug_clock_enable
                                      : i_memory_clock_enable;

      // Mirrors for external chain decoders outside this block.
      nxt_st.ir_out = {1'b0, i_ir_code};
      nxt_st.tap_out = i_tap_state;
   end

   // State register. The clock enable freezes everything, synchronisers too,
   // which is harmless because no shift happens while it is low.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st_ff <= '0;
         st_ff.active <= dsc_pkg::CHAIN_RESET;
         st_ff.sel_sr <= dsc_pkg::SEL_CAPTURE_VAL;
      end else if (i_ce) begin
         st_ff <= nxt_st;
      end
   end

   // All outputs come straight from the state record.
   assign o_test_data_out_pin = st_ff.tdo;
   assign o_active_chain_number = st_ff.active;
   assign o_current_instruction_out = st_ff.ir_out;
   assign o_tap_state_out = st_ff.tap_out;
   assign o_external_chain_serial_in = st_ff.ext_sdin;
   assign o_instruction_bus = st_ff.fetch_out;
   assign o_core_rdata = st_ff.rdata_out;
   assign o_sys_wdata = st_ff.wdata_out;
   assign o_system_speed_flag = st_ff.speed_out;
   assign o_watch_then_break_flag = st_ff.wtb_out;
   assign o_core_clock_enable = st_ff.core_clk_en;
   assign o_bpu_addr = st_ff.bpu_addr;
   assign o_bpu_wdata = st_ff.bpu_wdata;
   assign o_bpu_write = st_ff.bpu_wr;
   assign o_bpu_read = st_ff.bpu_rd;
endmodule // dsc_scan_chain_select

// ### dsc_ext_chain_model.sv
// External boundary chain model hanging between the external serial pins.
`timescale 1ns/1ps
module dsc_ext_chain_model (
   input wire logic i_clk,
   input wire logic i_serial_in,
   input wire logic [4:0] i_active,
   input wire logic [4:0] i_instruction_bus,
   input wire logic [3:0] i_tap,
   input wire logic i_dbg_en,
   output logic o_return
);
   logic [7:0] chain_ff = 8'h3C;
   logic sel;
   // Chain decode from the exported signals; a second chain would share this decode.
   assign sel = (i_active == dsc_pkg::CHAIN_EXT) || i_active[4];
   // Shift only on debug-enabled shift cycles of the internal test instruction.
   always_ff @(posedge i_clk) begin
      if (sel && i_dbg_en && i_tap == dsc_pkg::TAP_SHIFT_DR &&
          i_instruction_bus[3:0] == dsc_pkg::IR_INTERNAL_TEST) begin
         chain_ff <= {i_serial_in, chain_ff[7:1]};
      end
   end
   // A deselected chain shows the inverse of its last bit, so stale data never passes.
   assign o_return = sel ? chain_ff[0] : ~chain_ff[0];
endmodule // dsc_ext_chain_model

// ### dsc_scan_chain_select_sva.sv
// Concurrent checks on the ports of the debug scan datapath.
`timescale 1ns/1ps
module dsc_scan_chain_select_sva (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_debug_clock_enable,
   input wire logic i_memory_clock_enable,
   input wire logic i_in_debug,
   input wire logic [3:0] i_ir_code,
   input wire logic [3:0] i_tap_state,
   input wire logic o_test_data_out_pin,
   input wire logic [4:0] o_active_chain_number,
   input wire logic [4:0] o_current_instruction_out,
   input wire logic [3:0] o_tap_state_out,
   input wire logic o_external_chain_serial_in,
   input wire logic o_core_clock_enable,
   input wire logic o_bpu_write,
   input wire logic o_bpu_read
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // Qualified select-register steps; ce and debug enable gate every transfer.
   logic sel_cap, sel_sh;
   assign sel_cap = i_ce && i_debug_clock_enable && i_ir_code == dsc_pkg::IR_CHAIN_SELECT &&
                    i_tap_state == dsc_pkg::TAP_CAPTURE_DR;
   assign sel_sh = i_ce && i_debug_clock_enable && i_ir_code == dsc_pkg::IR_CHAIN_SELECT &&
                   i_tap_state == dsc_pkg::TAP_SHIFT_DR;
   property p_reset_chain;
      $fell(i_sys_rst) |-> o_active_chain_number == dsc_pkg::CHAIN_RESET;
   endproperty
   a_reset_chain: assert property (p_reset_chain) else $error("active chain not 3 after reset");
   property p_chain_hold;
      $changed(o_active_chain_number) |-> $past(i_tap_state) == dsc_pkg::TAP_UPDATE_DR &&
         $past(i_ir_code) == dsc_pkg::IR_CHAIN_SELECT && $past(i_debug_clock_enable);
   endproperty
   a_chain_hold: assert property (p_chain_hold) else $error("active chain changed unasked");
   sequence s_sel_out;
      sel_cap ##1 sel_sh [*5];
   endsequence
   property p_capture_val;
      s_sel_out |=> o_test_data_out_pin == 1'b1 && $past(o_test_data_out_pin, 4) == 1'b0;
   endproperty
   a_capture_val: assert property (p_capture_val) else $error("select capture not 10000");
   property p_core_en;
      !$past(i_sys_rst) && $past(i_ce) |-> o_core_clock_enable ==
         ($past(i_in_debug) ? $past(i_debug_clock_enable) : $past(i_memory_clock_enable));
   endproperty
   a_core_en: assert property (p_core_en) else $error("core clock enable wrong source");
   property p_state_out;
      !$past(i_sys_rst) && $past(i_ce) |-> o_tap_state_out == $past(i_tap_state) &&
         o_current_instruction_out == {1'b0, $past(i_ir_code)};
   endproperty
   a_state_out: assert property (p_state_out) else $error("exported tap signals wrong");
   property p_bpu_write;
      o_bpu_write |-> $past(i_tap_state) == dsc_pkg::TAP_UPDATE_DR && !o_bpu_read &&
         o_active_chain_number == dsc_pkg::CHAIN_BPU ##1 !o_bpu_write;
   endproperty
   a_bpu_write: assert property (p_bpu_write) else $error("breakpoint write strobe wrong");
   property p_tdo_shift;
      $changed(o_test_data_out_pin) |-> $past(i_tap_state) == dsc_pkg::TAP_SHIFT_DR &&
         $past(i_debug_clock_enable);
   endproperty
   a_tdo_shift: assert property (p_tdo_shift) else $error("serial out moved off a shift");
   property p_ext_shift;
      $changed(o_external_chain_serial_in) |-> $past(i_tap_state) == dsc_pkg::TAP_SHIFT_DR &&
         $past(i_debug_clock_enable);
   endproperty
   a_ext_shift: assert property (p_ext_shift) else $error("external serial moved off a shift");
   property p_bpu_read;
      o_bpu_read |-> $past(i_tap_state) == dsc_pkg::TAP_UPDATE_DR ##1 !o_bpu_read;
   endproperty
   a_bpu_read: assert property (p_bpu_read) else $error("breakpoint read strobe wrong");
   c_write: cover property (o_bpu_write);
   c_read: cover property (o_bpu_read);
   c_select: cover property (s_sel_out);
endmodule // dsc_scan_chain_select_sva
bind dsc_scan_chain_select dsc_scan_chain_select_sva u_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_ce(i_ce), .i_debug_clock_enable(i_debug_clock_enable),
   .i_memory_clock_enable(i_memory_clock_enable), .i_in_debug(i_in_debug),
   .i_ir_code(i_ir_code), .i_tap_state(i_tap_state), .o_test_data_out_pin(o_test_data_out_pin),
   .o_active_chain_number(o_active_chain_number),
   .o_current_instruction_out(o_current_instruction_out), .o_tap_state_out(o_tap_state_out),
   .o_external_chain_serial_in(o_external_chain_serial_in),
   .o_core_clock_enable(o_core_clock_enable), .o_bpu_write(o_bpu_write), .o_bpu_read(o_bpu_read));

// ### dsc_scan_chain_select_bench.sv
// Self-checking bench driving the scan datapath through TAP state sequences.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
   $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module dsc_scan_chain_select_bench;
   logic i_clk = 0, rst = 1, dbg = 1, mem = 1, indbg = 0, tdi = 0, ret, tdo, ext_in, cwr = 1;
   logic entry = 0, wpt = 1, wtb = 1, speed, wtbf, cen, bw, br, ce = 1;
   logic [3:0] ir = 4'hF, tap = 4'hF, tap_o;
   logic [4:0] act, ir_o, baddr;
   logic [31:0] fetch = 32'hA5C30F1E, srd = 32'h0BADF00D, cwd = 32'h12345678, brd = 32'h13579BDF;
   logic [31:0] ibus, crd, swd, bwd, rev;
   logic [66:0] d, din;
   int miscompares = 0, n_compared = 0, n_wr = 0, n_rd = 0;
   always #2.5 i_clk = ~i_clk;
   dsc_scan_chain_select dut (.i_clk(i_clk), .i_sys_rst(rst), .i_ce(ce),
      .i_debug_clock_enable(dbg), .i_memory_clock_enable(mem), .i_in_debug(indbg),
      .i_ir_code(ir), .i_tap_state(tap), .i_test_data_in_pin(tdi), .o_test_data_out_pin(tdo),
      .o_active_chain_number(act), .o_current_instruction_out(ir_o), .o_tap_state_out(tap_o),
      .o_external_chain_serial_in(ext_in), .i_external_chain_serial_return(ret),
      .i_sys_fetch_word(fetch), .i_sys_rdata(srd), .i_core_wdata(cwd), .i_core_write(cwr),
      .i_debug_entry(entry), .i_entry_watchpoint(wpt), .i_watch_then_break(wtb),
      .o_instruction_bus(ibus), .o_core_rdata(crd), .o_sys_wdata(swd),
      .o_system_speed_flag(speed), .o_watch_then_break_flag(wtbf), .o_core_clock_enable(cen),
      .o_bpu_addr(baddr), .o_bpu_wdata(bwd), .o_bpu_write(bw), .o_bpu_read(br),
      .i_bpu_rdata(brd));
   dsc_ext_chain_model u_ext (.i_clk(i_clk), .i_serial_in(ext_in), .i_active(act),
      .i_instruction_bus(ir_o), .i_tap(tap_o), .i_dbg_en(dbg), .o_return(ret));
   // Strobe counters, so pulse checks do not depend on the exact cycle of the pulse.
   always @(posedge i_clk) begin
      if (bw === 1'b1) n_wr++;
      if (br === 1'b1) n_rd++;
   end
   // One data-register pass; serial in leads the shift by two cycles of synchroniser.
   task automatic scan(input logic [3:0] code, input int n, input logic [66:0] di,
                       output logic [66:0] dq);
      dq = '0;
      @(posedge i_clk) #1 ir = code;
      tap = 4'hF;
      tdi = di[0];
      @(posedge i_clk) #1 tap = dsc_pkg::TAP_CAPTURE_DR;
      tdi = di[1];
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk) #1 tap = dsc_pkg::TAP_SHIFT_DR;
         tdi = (i + 2 < 67) ? di[i + 2] : 1'b0;
         if (i > 0) dq[i - 1] = tdo;
      end
      @(posedge i_clk) #1 tap = dsc_pkg::TAP_UPDATE_DR;
      dq[n - 1] = tdo;
      @(posedge i_clk) #1 tap = 4'hF;
      repeat (3) @(posedge i_clk);
      #1;
   endtask
   task automatic end_of_test();
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #20000;
      miscompares++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge i_clk);
      #1 rst = 0;
      `CHK("reset chain", dsc_pkg::CHAIN_RESET, act)
      `CHK("core enable reset", 1'b0, cen)
      scan(dsc_pkg::IR_CHAIN_SELECT, 5, 67'h11, d);
      `CHK("select capture", dsc_pkg::SEL_CAPTURE_VAL, d[4:0])
      `CHK("chain 17", 5'h11, act)
      scan(dsc_pkg::IR_INTERNAL_TEST, 67, {17{4'h5}}, d);
      `CHK("external path", 1'b1, d[66:40] != 0 && ~d[66:40] != 0)
      scan(dsc_pkg::IR_CHAIN_SELECT, 5, 67'h00, d);
      scan(dsc_pkg::IR_INTERNAL_TEST, 67, {17{4'h5}}, d);
      `CHK("reserved holds", {66{d[0]}}, d[66:1])
      dbg = 0;
      scan(dsc_pkg::IR_CHAIN_SELECT, 5, 67'h02, d);
      dbg = 1;
      `CHK("refused select", 5'h00, act)
      // A low clock enable must freeze the whole select pass.
      ce = 0;
      scan(dsc_pkg::IR_CHAIN_SELECT, 5, 67'h02, d);
      ce = 1;
      `CHK("frozen select", 5'h00, act)
      scan(dsc_pkg::IR_CHAIN_SELECT, 5, 67'h02, d);
      scan(dsc_pkg::IR_INTERNAL_TEST, 38, {1'b1, 5'h0A, 32'hDEADBEEF}, d);
      `CHK("bpu addr", 5'h0A, baddr)
      `CHK("bpu data", 32'hDEADBEEF, bwd)
      `CHK("bpu writes", 1, n_wr)
      `CHK("chain kept", dsc_pkg::CHAIN_BPU, act)
      scan(dsc_pkg::IR_INTERNAL_TEST, 38, {1'b0, 5'h05, 32'h0}, d);
      `CHK("bpu reads", 1, n_rd)
      scan(dsc_pkg::IR_INTERNAL_TEST, 38, 67'h0, d);
      `CHK("bpu read data", brd, d[31:0])
      `CHK("bpu read addr", 5'h05, d[36:32])
      scan(dsc_pkg::IR_CHAIN_SELECT, 5, 67'h01, d);
      din = '0;
      din[31:0] = 32'hCAFEF00D;
      din[34] = 1'b1;
      din[32] = 1'b0;
      for (int k = 0; k < 32; k++) din[35 + k] = 32'hE1A00000 >> (31 - k);
      @(posedge i_clk) #1 entry = 1;
      @(posedge i_clk) #1 entry = 0;
      scan(dsc_pkg::IR_INTERNAL_TEST, 67, din, d);
      for (int k = 0; k < 32; k++) rev[k] = d[66 - k];
      `CHK("fetch capture", fetch, rev)
      `CHK("write capture", cwd, d[31:0])
      `CHK("entry flags", 3'b110, d[34:32])
      `CHK("scanned fetch", 32'hE1A00000, ibus)
      `CHK("scanned rdata", 32'hCAFEF00D, crd)
      `CHK("speed flag", 1'b1, speed)
      `CHK("wtb flag", 1'b0, wtbf)
      @(posedge i_clk) #1 ir = dsc_pkg::IR_EXTERNAL_TEST;
      mem = 0;
      indbg = 1;
      repeat (3) @(posedge i_clk);
      #1;
      `CHK("system fetch", fetch, ibus)
      `CHK("system rdata", srd, crd)
      `CHK("system wdata", cwd, swd)
      `CHK("debug enable", 1'b1, cen)
      end_of_test();
   end
endmodule // dsc_scan_chain_select_bench
